// File: aspc_pkg.sv
// Package of constants and types for the converter serial power-down control
package aspc_pkg;
  // Clock period of clk_in in ns
  localparam int CLK_PERIOD_NS = 25;
  // Result width
  localparam int RESULT_W = 12;
  // Bits in one output word: flag plus result
  localparam int WORD_BITS = 13;
  // Light power-down wake time in ns, longest, rounded down
  localparam int NAP_WAKE_NS = 350;
  localparam int NAP_WAKE_CYC = (NAP_WAKE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                (NAP_WAKE_NS / CLK_PERIOD_NS);
  // Reference settling in us (typical 2.5 ms)
  localparam int REF_SETTLE_US = 2500;
  localparam int REF_SETTLE_CYC = REF_SETTLE_US * 1000 / CLK_PERIOD_NS;
  // Least strobe-to-clock interval in ns
  localparam int STROBE_CLK_MIN_NS = 50;
  localparam int STROBE_CLK_MIN_CYC = (STROBE_CLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe pulse counts that select a power-down state
  localparam logic [2:0] NAP_PULSES = 3'h2;
  localparam logic [2:0] SLEEP_PULSES = 3'h4;
  // Power states
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_NAP = 2'b01,
    PWR_SLEEP = 2'b10,
    PWR_SETTLE = 2'b11
  } aspc_pwr_t;
endpackage

// File: aspc_edge.sv
// Edge detector for a pin taken as synchronous to the clock
`timescale 1ns/1ps
module aspc_edge (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sig_in,
  output logic rise_out,
  output logic fall_out,
  output logic level_out
);
  logic last_q;
  // Previous sample, reset low so a high level after reset reads as a rise
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      last_q <= 1'b0;
    end else begin
      last_q <= sig_in;
    end
  end
  assign rise_out = sig_in & ~last_q;
  assign fall_out = ~sig_in & last_q;
  assign level_out = last_q;
endmodule // aspc_edge

// File: aspc_ctrl.sv
// Serial interface and power-down control of a 12-bit sampling converter
`timescale 1ns/1ps
// Functional notes
// [RULE_01] After reset the block is active and accepts a conversion at once.
// [RULE_02] Two strobe pulses with serial clock low enter light power-down.
// [RULE_03] Four strobe pulses with serial clock low enter deep sleep.
// [RULE_04] Power-down entry happens on the falling edge of the last pulse.
// [RULE_05] Light power-down keeps only the reference on.
// [RULE_06] Deep sleep turns everything off, reference included.
// [RULE_07] A rising serial clock edge wakes from either power-down state.
// [RULE_08] From light power-down, ready to convert within 350 ns.
// [RULE_09] Reference settling after deep sleep modelled as 2.5 ms.
// [RULE_10] After deep sleep stay in light power-down until reference ready.
// [RULE_11] Output word is settled flag first, then the 12-bit result.
// [RULE_12] Conversions during the settle interval return all zeros.
// [RULE_13] Serial output is not driven while no conversion runs.
// [RULE_14] A strobe rising edge starts a conversion.
// [RULE_15] Strobe rises during a conversion are ignored.
// [RULE_16] Too-early clock after the strobe delays the word by one clock.
// [RULE_17] The output bit changes on each serial clock rising edge.
// [RULE_18] Host samples each bit on the rising clock edge.
// [RULE_19] Three lines: clock and strobe in, serial result out.
// [RULE_20] Host keeps the serial clock at or below 9.6 MHz.
// [RULE_21] Reference held below nominal forces the settled flag low.
// [RULE_22] Unipolar result is straight binary, bipolar is two's complement.
// [RULE_23] The strobe pulse counter clears on each serial clock rise.
module aspc_ctrl
  import aspc_pkg::*;
#(
  parameter int SETTLE_CYCLES = REF_SETTLE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic convert_strobe_in,
  input wire logic [RESULT_W-1:0] sample_in,
  input wire logic bipolar_in,
  input wire logic ref_low_in,
  output logic sdata_out,
  output logic sdata_oe_out,
  output logic ref_power_out,
  output logic core_power_out,
  output logic ready_out,
  output logic reference_settled_flag_out,
  output logic busy_out
);
  // ****************************************
  // Pin edges
  // ****************************************
  logic sclk_rise;
  logic cs_rise;
  logic cs_fall;
  // Only the clock rise matters here; its level is read straight from the pin
  aspc_edge u_sclk_edge (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sig_in(sclk_in),
    .rise_out(sclk_rise),
    .fall_out(),
    .level_out()
  );
  // Strobe rise starts a conversion, strobe fall counts a power-down pulse
  aspc_edge u_cs_edge (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .sig_in(convert_strobe_in),
    .rise_out(cs_rise),
    .fall_out(cs_fall),
    .level_out()
  );

  // ****************************************
  // Power state
  // ****************************************
  aspc_pwr_t pwr_q;
  aspc_pwr_t pwr_d;
  logic [2:0] pulse_q;
  logic [2:0] pulse_d;
  logic [21:0] settle_q;
  logic [21:0] settle_d;
  logic [3:0] wake_q;
  logic [3:0] wake_d;
  logic settle_done;
  logic nap_hit;
  logic sleep_hit;
  logic pd_enter;
  logic busy_q;

  // Pulse count including a pulse ending this cycle with the clock low
  logic [2:0] pulse_next;
  assign pulse_next = pulse_q + 3'h1;
  assign nap_hit = cs_fall & ~sclk_in & (pulse_next == NAP_PULSES); // RULE_02
  assign sleep_hit = cs_fall & ~sclk_in & (pulse_next == SLEEP_PULSES); // RULE_03
  // Leaving active aborts a half-done word so that it never resumes after wake
  assign pd_enter = (pwr_q == PWR_ACTIVE) & (nap_hit | sleep_hit); // RULE_04
  assign settle_done = (settle_q == 22'(SETTLE_CYCLES - 1)); // RULE_09

  // Counter restarts on each clock rise; only back-to-back pulses count.
  // The first pulse also starts a conversion, so busy must not block the count.
  always_comb begin
    pulse_d = pulse_q;
    if (sclk_rise) begin
      pulse_d = 3'h0; // RULE_23
    end else if (cs_fall && !sclk_in) begin
      pulse_d = (pulse_next == SLEEP_PULSES) ? 3'h0 : pulse_next;
    end
  end

  // Next power state
  always_comb begin
    pwr_d = pwr_q;
    settle_d = settle_q;
    wake_d = (wake_q != 4'h0) ? wake_q - 4'h1 : 4'h0;
    case (pwr_q)
      PWR_ACTIVE: begin
        // Nap is entered at the second pulse and then deepened at the fourth
        if (sleep_hit) begin
          pwr_d = PWR_SLEEP; // RULE_04
        end else if (nap_hit) begin
          pwr_d = PWR_NAP; // RULE_04
        end
      end
      PWR_NAP: begin
        if (sleep_hit) begin
          pwr_d = PWR_SLEEP; // RULE_03
        end else if (sclk_rise) begin
          pwr_d = PWR_ACTIVE; // RULE_07
          wake_d = 4'(NAP_WAKE_CYC); // RULE_08
        end
      end
      PWR_SLEEP: begin
        if (sclk_rise) begin
          pwr_d = PWR_SETTLE; // RULE_07
          settle_d = 22'h0;
        end
      end
      PWR_SETTLE: begin
        // Reference ramps while the rest stays in light power-down
        if (settle_done) begin
          pwr_d = PWR_ACTIVE; // RULE_10
        end else begin
          settle_d = settle_q + 22'h1;
        end
      end
      default: begin
        pwr_d = PWR_ACTIVE;
      end
    endcase
  end

  // Power state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pwr_q <= PWR_ACTIVE; // RULE_01
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // Power-down pulse counter
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pulse_q <= 3'h0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  // Reference settle timer, only meaningful after deep sleep
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      settle_q <= 22'h0;
    end else begin
      settle_q <= settle_d;
    end
  end

  // Nap wake timer; the core stays off until it runs out
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wake_q <= 4'h0;
    end else begin
      wake_q <= wake_d;
    end
  end

  // Supplies: nap and settle keep only the reference alive
  assign ref_power_out = (pwr_q != PWR_SLEEP); // RULE_05 RULE_06
  assign core_power_out = (pwr_q == PWR_ACTIVE) & (wake_q == 4'h0); // RULE_05
  // The comparator is the last part to wake, so ready follows its supply
  assign ready_out = core_power_out;
  // Flag is low while waking or settling, or with the reference pulled down;
  // the pin shows the same value that a word started now would carry
  logic flag_now;
  assign flag_now = core_power_out & ~ref_low_in; // RULE_21
  assign reference_settled_flag_out = flag_now;

  // ****************************************
  // Conversion and shifting
  // ****************************************
  logic [WORD_BITS-1:0] word_q;
  logic [WORD_BITS-1:0] word_d;
  logic [3:0] bits_q;
  logic [3:0] bits_d;
  logic [1:0] early_q;
  logic [1:0] early_d;
  logic skip_q;
  logic skip_d;
  logic oe_q;
  logic oe_d;
  logic dout_q;
  logic dout_d;
  logic busy_d;
  logic start;
  logic [RESULT_W-1:0] coded;

  // Straight binary input; bipolar flips the sign bit for two's complement
  assign coded = bipolar_in ? {~sample_in[RESULT_W-1], sample_in[RESULT_W-2:0]}
                            : sample_in; // RULE_22
  // Conversions in sleep are not possible; settle interval returns zeros
  assign start = cs_rise & ~busy_q & (pwr_q == PWR_ACTIVE || pwr_q == PWR_SETTLE); // RULE_14 RULE_15

  always_comb begin
    word_d = word_q;
    bits_d = bits_q;
    busy_d = busy_q;
    early_d = (early_q != 2'h0) ? early_q - 2'h1 : 2'h0;
    skip_d = skip_q;
    oe_d = oe_q;
    dout_d = dout_q;
    if (pd_enter) begin
      // Power-down entry drops the pending word and releases the pin
      busy_d = 1'b0; // RULE_05
      oe_d = 1'b0; // RULE_13
      bits_d = 4'h0;
    end else if (start) begin
      busy_d = 1'b1;
      bits_d = 4'h0;
      early_d = 2'(STROBE_CLK_MIN_CYC);
      skip_d = 1'b0;
      if (flag_now && core_power_out) begin
        word_d = {1'b1, coded}; // RULE_11
      end else if (pwr_q == PWR_SETTLE) begin
        word_d = '0; // RULE_12
      end else begin
        word_d = {1'b0, coded}; // RULE_21
      end
    end else if (busy_q && sclk_rise) begin
      // Only one rise is swallowed, so the word slips by exactly one clock
      if (early_q != 2'h0 && bits_q == 4'h0 && !oe_q && !skip_q) begin
        skip_d = 1'b1; // RULE_16
      end else if (bits_q == 4'(WORD_BITS)) begin
        busy_d = 1'b0; // RULE_13
        oe_d = 1'b0;
      end else begin
        // New bit on each rise, host samples it on the next rise
        oe_d = 1'b1;
        dout_d = word_q[WORD_BITS-1]; // RULE_17 RULE_18
        word_d = {word_q[WORD_BITS-2:0], 1'b0};
        bits_d = bits_q + 4'h1;
      end
    end
  end

  // Shift register and bit count
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word_q <= '0;
      bits_q <= 4'h0;
    end else begin
      word_q <= word_d;
      bits_q <= bits_d;
    end
  end

  // Conversion progress and the early-clock guard
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_q <= 1'b0;
      early_q <= 2'h0;
      skip_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      early_q <= early_d;
      skip_q <= skip_d;
    end
  end

  // Pin registers: bit and enable change together on a clock rise
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      oe_q <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
      dout_q <= dout_d;
    end
  end

  // Three-line interface: the output pin is driven only mid-word
  assign sdata_out = dout_q; // RULE_19
  assign sdata_oe_out = oe_q; // RULE_13
  assign busy_out = busy_q;
endmodule // aspc_ctrl

// File: aspc_ctrl_monitor.sv
// Port-level checker of the converter serial control
`timescale 1ns/1ps
module aspc_ctrl_monitor
  import aspc_pkg::*;
#(
  parameter int SETTLE_CYCLES = REF_SETTLE_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic convert_strobe_in,
  input wire logic [RESULT_W-1:0] sample_in,
  input wire logic bipolar_in,
  input wire logic ref_low_in,
  input wire logic sdata_out,
  input wire logic sdata_oe_out,
  input wire logic ref_power_out,
  input wire logic core_power_out,
  input wire logic ready_out,
  input wire logic reference_settled_flag_out,
  input wire logic busy_out
);
  logic slp_q;
  int cnt_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ****************
  // Checks
  // ****************
  // Settle path is told from nap only by the sleep seen before it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      slp_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      slp_q <= !ref_power_out || (slp_q && !core_power_out);
      cnt_q <= (slp_q && ref_power_out && !core_power_out) ? cnt_q + 1 : 0;
    end
  end
  // Wake events
  sequence s_sclk_rise;
    $rose(sclk_in);
  endsequence
  sequence s_nap_wake;
    !slp_q && ref_power_out && !core_power_out ##0 s_sclk_rise;
  endsequence
  sequence s_slp_wake;
    !ref_power_out ##0 s_sclk_rise;
  endsequence
  AST_OE_IDLE: assert property (!busy_out |-> !sdata_oe_out)
    else $error("serial output driven while idle");
  AST_START: assert property ($rose(convert_strobe_in) && !busy_out && ready_out |=> busy_out)
    else $error("strobe rise started no conversion");
  AST_REFUSE: assert property (busy_out && ready_out && !sclk_in && $rose(convert_strobe_in) |=> busy_out)
    else $error("strobe rise disturbed a conversion");
  AST_SLEEP_OFF: assert property (!ref_power_out |-> !core_power_out && !ready_out)
    else $error("core powered while reference off");
  AST_FLAG_LOW: assert property (ref_low_in || !ready_out |-> !reference_settled_flag_out)
    else $error("settled flag high with low reference");
  AST_NAP_WAKE: assert property (s_nap_wake |-> ##[1:15] core_power_out)
    else $error("nap wake too slow");
  AST_SLP_WAKE: assert property (s_slp_wake |=> ref_power_out && !core_power_out)
    else $error("sleep wake did not pass through nap");
  AST_SETTLE_LEN: assert property ($rose(core_power_out) && slp_q |->
      cnt_q >= SETTLE_CYCLES - 2 && cnt_q <= SETTLE_CYCLES + 2)
    else $error("settle interval length wrong");
  AST_BIT_STEP: assert property ($changed(sdata_out) && $past(sdata_oe_out) |->
      $past(sclk_in) && !$past(sclk_in, 2))
    else $error("serial bit changed without clock rise");
endmodule // aspc_ctrl_monitor

// File: aspc_host.sv
// Host serial port model: drives clock and strobe, shifts in the word
`timescale 1ns/1ps
module aspc_host (
  input wire logic clk_in,
  input wire logic sdata_in,
  input wire logic sdata_oe_in,
  output logic sclk_out = 1'b0,
  output logic strobe_out = 1'b0
);
  logic last_q = 1'b0;
  // ****************
  // Line and tasks
  // ****************
  // Released line toggles so a stale bit is never read as good
  wire line = sdata_oe_in ? sdata_in : ~last_q;
  always_ff @(posedge clk_in) last_q <= line;
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // Five MHz shift clock, under the device limit
  task automatic sclk_pulse();
    sclk_out = 1'b1;
    wait_n(4);
    sclk_out = 1'b0;
    wait_n(4);
  endtask
  // Strobe pulses with the shift clock held low
  task automatic strobe_pulses(input int n);
    repeat (n) begin
      strobe_out = 1'b1;
      wait_n(2);
      strobe_out = 1'b0;
      wait_n(2);
    end
  endtask
  // One word over the three lines; optional early clock and extra strobe
  task automatic convert(input bit early, input bit twice, output logic [12:0] w);
    strobe_out = 1'b1;
    wait_n(1);
    if (early) begin
      sclk_out = 1'b1;
      wait_n(1);
      sclk_out = 1'b0;
    end
    wait_n(3);
    strobe_out = 1'b0;
    for (int i = 0; i < 14; i++) begin
      if (i > 0) w[13 - i] = line;
      sclk_pulse();
      strobe_out = twice && i == 5;
    end
  endtask
endmodule // aspc_host

// File: tb_aspc_ctrl.sv
// Self-checking testbench of the converter serial power-down control
`timescale 1ns/1ps
module tb_aspc_ctrl;
  import aspc_pkg::*;
  localparam int SETTLE = 200;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [11:0] sample = 12'ha5c;
  logic bipolar = 1'b0;
  logic ref_low = 1'b0;
  logic sclk, strobe, sdata, sdata_oe, ref_pwr, core_pwr, ready, flag, busy;
  int err_total = 0;
  int tests_run = 0;
  wire [12:0] pwr = {11'h0, ref_pwr, core_pwr};
  wire [12:0] idle = {11'h0, busy, sdata_oe};
  // ****************
  // Bench
  // ****************
  aspc_ctrl #(.SETTLE_CYCLES(SETTLE)) aspc_ctrl_i (
    .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk), .convert_strobe_in(strobe),
    .sample_in(sample), .bipolar_in(bipolar), .ref_low_in(ref_low), .sdata_out(sdata),
    .sdata_oe_out(sdata_oe), .ref_power_out(ref_pwr), .core_power_out(core_pwr),
    .ready_out(ready), .reference_settled_flag_out(flag), .busy_out(busy));
  aspc_host host_i (.clk_in(clk_in), .sdata_in(sdata), .sdata_oe_in(sdata_oe),
    .sclk_out(sclk), .strobe_out(strobe));
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset(input int n);
    rst_in = 1'b1;
    host_i.wait_n(n);
    rst_in = 1'b0;
  endtask
  task automatic run_word(input logic [12:0] exp, input bit early, input bit twice);
    logic [12:0] w;
    host_i.convert(early, twice, w);
    chk("word", exp, w);
    chk("idle", 13'h0, idle);
  endtask
  task automatic t_words();
    run_word({1'b1, 12'ha5c}, 1'b0, 1'b0);
    bipolar = 1'b1;
    run_word({1'b1, 12'h25c}, 1'b0, 1'b0);
    bipolar = 1'b0;
    ref_low = 1'b1;
    run_word({1'b0, 12'ha5c}, 1'b0, 1'b0);
    ref_low = 1'b0;
  endtask
  task automatic t_early();
    run_word({1'b1, 12'ha5c}, 1'b1, 1'b0);
  endtask
  task automatic t_refuse();
    run_word({1'b1, 12'ha5c}, 1'b0, 1'b1);
  endtask
  // Wake checked at the limit; eight cycles already pass in the pulse
  task automatic t_nap();
    host_i.strobe_pulses(1);
    chk("pwr", 13'h3, pwr);
    host_i.strobe_pulses(1);
    chk("pwr", 13'h2, pwr);
    host_i.sclk_pulse();
    host_i.wait_n(NAP_WAKE_CYC - 7);
    chk("pwr", 13'h3, pwr);
  endtask
  task automatic t_sleep();
    do_reset(2);
    host_i.strobe_pulses(4);
    chk("pwr", 13'h0, pwr);
    host_i.sclk_pulse();
    chk("pwr", 13'h2, pwr);
    run_word(13'h0, 1'b0, 1'b0);
    host_i.wait_n(SETTLE);
    chk("pwr", 13'h3, pwr);
    run_word({1'b1, 12'ha5c}, 1'b0, 1'b0);
  endtask
  task automatic t_count();
    do_reset(2);
    host_i.strobe_pulses(1);
    host_i.sclk_pulse();
    host_i.strobe_pulses(1);
    chk("pwr", 13'h3, pwr);
  endtask
  initial begin
    do_reset(20);
    t_words();
    t_early();
    t_refuse();
    t_nap();
    t_sleep();
    t_count();
    tally_and_finish();
  end
  // Run needs about eleven hundred cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    tally_and_finish();
  end
endmodule // tb_aspc_ctrl
bind aspc_ctrl aspc_ctrl_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) aspc_ctrl_monitor_i (
  .clk_in(clk_in), .rst_in(rst_in), .sclk_in(sclk_in), .convert_strobe_in(convert_strobe_in),
  .sample_in(sample_in), .bipolar_in(bipolar_in), .ref_low_in(ref_low_in),
  .sdata_out(sdata_out), .sdata_oe_out(sdata_oe_out), .ref_power_out(ref_power_out),
  .core_power_out(core_power_out), .ready_out(ready_out),
  .reference_settled_flag_out(reference_settled_flag_out), .busy_out(busy_out));
